// ### hdl/hrdop_channel.sv
// one pwm channel with outputs a and b, edge events, sync and an ahb-lite register port
//
// Summary of operation
// - duty input is signed q23, converted to on-time
// - sixteen-phase hires sub-step, enable and step select
// - sync input resets the period counter
// - sync output when counter crosses phase value
// - fourteen bit programmable period time base
// - period write lands in shadow, applied at wrap
// - signed cycle adjust in 250 ps steps
// - per-output selectable polarity
// - sample trigger match fires error converter conversion
// - counter runs zero to period, then restarts
// - events 2-4 hold 14 whole plus 4 sub bits
// - hires only on events 2-4, event 1 whole
// - multi mode edges from events plus adjusts
// - sample triggers and blanking always from registers
// - oversampling gives 1, 2, 4 or 8 triggers
// - period interrupt every divide count plus one periods
// - divided interrupt also starts general converter sequence
// - normal mode a fall and b rise follow filter duty
// - adaptive triggers follow duty plus offset, normal mode only
// - cycle adjust b ignored in normal mode
// - signals change when counter reaches their target
`timescale 1ns/100ps
`default_nettype none
module hrdop_channel (
	// clock and reset
	input  wire logic                 core_clk,
	input  wire logic                 rst_b,
	// ahb-lite slave
	input  wire logic                 hsel,
	input  wire logic [31:0]          haddr,
	input  wire logic [1:0]           htrans,
	input  wire logic                 hwrite,
	input  wire logic [2:0]           hsize,
	input  wire logic [31:0]          hwdata,
	input  wire logic                 hready,
	output logic                      hreadyout,
	output logic [31:0]               hrdata,
	output logic                      hresp,
	// filter side
	input  wire logic [23:0]          filter_duty,
	// synchronisation
	input  wire logic                 sync_in,
	output logic                      sync_out,
	output logic [13:0]               phase_offset,
	// switch drivers
	output logic                      pwm_a,
	output logic                      pwm_b,
	output logic [3:0]                hires_a,
	output logic [3:0]                hires_b,
	// triggers and windows
	output logic                      conv_trig,
	output logic                      conv_trig2,
	output logic                      adapt_trig_a,
	output logic                      adapt_trig_b,
	output logic                      blank_a,
	output logic                      blank_b,
	output logic                      period_int,
	output logic                      gp_conv_trig
);
	localparam int CW = hrdop_pkg::CNT_W;
	localparam int EW = hrdop_pkg::EDGE_W;

	////////////////////////////////////////////////////////////////////////////
	// register bus

	logic [31:0]   ctrl_r;
	logic [CW-1:0] period_sh_r;
	logic [CW-1:0] period_r;
	logic [CW-1:0] ev1_r;
	logic [EW-1:0] ev2_r;
	logic [EW-1:0] ev3_r;
	logic [EW-1:0] ev4_r;
	logic [15:0]   adj_a_r;
	logic [15:0]   adj_b_r;
	logic [CW-1:0] strig_r;
	logic [CW-1:0] strig2_r;
	logic [CW-1:0] phase_r;
	logic [15:0]   adapt_r;
	logic [31:0]   blank_a_r;
	logic [31:0]   blank_b_r;
	logic          ap_wr_r;
	logic [7:0]    ap_addr_r;
	logic [CW-1:0] cnt_r;
	logic          a_lvl_r;
	logic          b_lvl_r;
	logic [31:0]   rd_mux;
	logic          ap_valid;

	assign ap_valid = hsel && htrans[1] && hready;

	// read mux, unmapped offsets read zero
	always_comb begin
		unique case (haddr[7:0])
			hrdop_pkg::OFS_CTRL:    rd_mux = ctrl_r;
			hrdop_pkg::OFS_PERIOD:  rd_mux = {18'h0, period_sh_r};
			hrdop_pkg::OFS_EV1:     rd_mux = {18'h0, ev1_r};
			hrdop_pkg::OFS_EV2:     rd_mux = {14'h0, ev2_r};
			hrdop_pkg::OFS_EV3:     rd_mux = {14'h0, ev3_r};
			hrdop_pkg::OFS_EV4:     rd_mux = {14'h0, ev4_r};
			hrdop_pkg::OFS_ADJ_A:   rd_mux = {16'h0, adj_a_r};
			hrdop_pkg::OFS_ADJ_B:   rd_mux = {16'h0, adj_b_r};
			hrdop_pkg::OFS_STRIG:   rd_mux = {18'h0, strig_r};
			hrdop_pkg::OFS_PHASE:   rd_mux = {18'h0, phase_r};
			hrdop_pkg::OFS_ADAPT:   rd_mux = {16'h0, adapt_r};
			hrdop_pkg::OFS_STRIG2:  rd_mux = {18'h0, strig2_r};
			hrdop_pkg::OFS_BLANK_A: rd_mux = blank_a_r;
			hrdop_pkg::OFS_BLANK_B: rd_mux = blank_b_r;
			hrdop_pkg::OFS_STATUS:  rd_mux = {14'h0, pwm_b, pwm_a, 2'h0, cnt_r};
			default:                rd_mux = 32'h0000_0000;
		endcase
	end

	// zero-wait slave: address captured, read data registered in the address phase
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			ap_wr_r   <= 1'b0;
			ap_addr_r <= 8'h00;
			hrdata    <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			ap_wr_r   <= ap_valid && hwrite;
			ap_addr_r <= haddr[7:0];
			if (ap_valid && !hwrite) begin
				hrdata <= rd_mux;
			end
		end
	end

	// register writes in the data phase; period goes to the shadow only
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_r      <= hrdop_pkg::CTRL_RST;
			period_sh_r <= hrdop_pkg::PERIOD_RST;
			ev1_r       <= 14'h0000;
			ev2_r       <= 18'h00000;
			ev3_r       <= 18'h00000;
			ev4_r       <= 18'h00000;
			adj_a_r     <= 16'h0000;
			adj_b_r     <= 16'h0000;
			strig_r     <= 14'h0000;
			strig2_r    <= 14'h0000;
			phase_r     <= 14'h0000;
			adapt_r     <= 16'h0000;
			blank_a_r   <= 32'h0000_0000;
			blank_b_r   <= 32'h0000_0000;
		end else if (ap_wr_r) begin
			unique case (ap_addr_r)
				hrdop_pkg::OFS_CTRL:    ctrl_r <= hwdata;
				hrdop_pkg::OFS_PERIOD:  period_sh_r <= hwdata[CW-1:0];
				hrdop_pkg::OFS_EV1:     ev1_r <= hwdata[CW-1:0];
				hrdop_pkg::OFS_EV2:     ev2_r <= hwdata[EW-1:0];
				hrdop_pkg::OFS_EV3:     ev3_r <= hwdata[EW-1:0];
				hrdop_pkg::OFS_EV4:     ev4_r <= hwdata[EW-1:0];
				hrdop_pkg::OFS_ADJ_A:   adj_a_r <= hwdata[15:0];
				hrdop_pkg::OFS_ADJ_B:   adj_b_r <= hwdata[15:0];
				hrdop_pkg::OFS_STRIG:   strig_r <= hwdata[CW-1:0];
				hrdop_pkg::OFS_PHASE:   phase_r <= hwdata[CW-1:0];
				hrdop_pkg::OFS_ADAPT:   adapt_r <= hwdata[15:0];
				hrdop_pkg::OFS_STRIG2:  strig2_r <= hwdata[CW-1:0];
				hrdop_pkg::OFS_BLANK_A: blank_a_r <= {2'h0, hwdata[29:16], 2'h0, hwdata[13:0]};
				hrdop_pkg::OFS_BLANK_B: blank_b_r <= {2'h0, hwdata[29:16], 2'h0, hwdata[13:0]};
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// control fields

	logic       run;
	logic       multi;
	logic       sync_en;
	logic [1:0] os_sel;
	logic [2:0] hr_sel;
	logic [7:0] div_set;

	assign run     = ctrl_r[hrdop_pkg::CTRL_RUN];
	assign multi   = ctrl_r[hrdop_pkg::CTRL_MULTI];
	assign sync_en = ctrl_r[hrdop_pkg::CTRL_SYNC_EN];
	assign os_sel  = ctrl_r[hrdop_pkg::CTRL_OS +: 2];
	assign hr_sel  = ctrl_r[hrdop_pkg::CTRL_HR_SEL +: 3];
	assign div_set = ctrl_r[hrdop_pkg::CTRL_DIV +: hrdop_pkg::DIV_W];

	////////////////////////////////////////////////////////////////////////////
	// time base

	logic wrap;
	logic sync_hit;

	assign wrap     = run && (cnt_r >= period_r);
	assign sync_hit = run && sync_en && sync_in;

	// period counter; sync has the same effect as a wrap on the count only
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_r <= 14'h0000;
		end else if (!run || sync_hit || wrap) begin
			cnt_r <= 14'h0000;
		end else begin
			cnt_r <= cnt_r + 14'h0001;
		end
	end

	// shadow period moves in only at the end of a period, or while stopped
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			period_r <= hrdop_pkg::PERIOD_RST;
		end else if (!run || wrap) begin
			period_r <= period_sh_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// duty conversion, latched per period so a pulse never sees two duties

	logic [22:0]   duty_pos;
	logic [36:0]   duty_prod;
	logic [EW-1:0] on_r;

	assign duty_pos  = filter_duty[23] ? 23'h000000 : filter_duty[22:0];
	assign duty_prod = {14'h0000, duty_pos} * {23'h000000, period_r};

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			on_r <= 18'h00000;
		end else if (!run || wrap) begin
			on_r <= duty_prod[36:19];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// edge targets in whole.sub units

	function automatic logic [EW-1:0] hrdop_sat(input logic signed [19:0] v);
		if (v[19]) begin
			return 18'h00000;
		end else if (v[18]) begin
			return 18'h3ffff;
		end
		return v[17:0];
	endfunction

	function automatic logic signed [19:0] hrdop_u(input logic [EW-1:0] v);
		return {2'b00, v};
	endfunction

	function automatic logic signed [19:0] hrdop_s(input logic [15:0] v);
		return {{4{v[15]}}, v};
	endfunction

	logic [EW-1:0] a_rise_e;
	logic [EW-1:0] a_fall_e;
	logic [EW-1:0] b_rise_e;
	logic [EW-1:0] b_fall_e;
	logic [EW-1:0] ast_a_e;
	logic [EW-1:0] ast_b_e;
	logic [EW-1:0] ev1_e;

	assign ev1_e    = {ev1_r, 4'h0};
	assign a_rise_e = ev1_e;

	always_comb begin
		if (multi) begin
			a_fall_e = hrdop_sat(hrdop_u(ev2_r) + hrdop_s(adj_a_r));
			b_rise_e = ev3_r;
			b_fall_e = hrdop_sat(hrdop_u(ev4_r) + hrdop_s(adj_b_r));
		end else begin
			a_fall_e = hrdop_sat(hrdop_u(ev1_e) + hrdop_u(on_r) + hrdop_s(adj_a_r));
			b_rise_e = hrdop_sat(hrdop_u(a_fall_e) + hrdop_u(ev3_r) - hrdop_u(ev2_r));
			b_fall_e = ev4_r;
		end
		ast_a_e = hrdop_sat(hrdop_u(ev1_e) + hrdop_u(on_r) + hrdop_s(adapt_r));
		ast_b_e = hrdop_sat(hrdop_u(ev1_e) + hrdop_u({1'b0, on_r[EW-1:1]})
			+ hrdop_s(adapt_r));
	end

	////////////////////////////////////////////////////////////////////////////
	// output edges, polarity and hires sub-step

	logic [3:0] hr_mask;
	logic       a_rise_hit;
	logic       a_fall_hit;
	logic       b_rise_hit;
	logic       b_fall_hit;
	logic       a_lvl_nxt;
	logic       b_lvl_nxt;
	logic       hr_on;

	// coarser steps drop low sub-step bits; a full drop gives 4 ns edges
	assign hr_mask = (hr_sel > 3'(hrdop_pkg::HR_SEL_MAX)) ? 4'h0 : 4'(4'hf << hr_sel);
	assign hr_on   = ctrl_r[hrdop_pkg::CTRL_HR_EN] && ctrl_r[hrdop_pkg::CTRL_PH_CLK];

	assign a_rise_hit = run && (a_rise_e[EW-1:4] == cnt_r);
	assign a_fall_hit = run && (a_fall_e[EW-1:4] == cnt_r);
	assign b_rise_hit = run && (b_rise_e[EW-1:4] == cnt_r);
	assign b_fall_hit = run && (b_fall_e[EW-1:4] == cnt_r);

	// a fall that coincides with the rise wins, so a zero width pulse stays off
	assign a_lvl_nxt = !run ? 1'b0 : a_fall_hit ? 1'b0 : a_rise_hit ? 1'b1 : a_lvl_r;
	assign b_lvl_nxt = !run ? 1'b0 : b_fall_hit ? 1'b0 : b_rise_hit ? 1'b1 : b_lvl_r;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			a_lvl_r <= 1'b0;
			b_lvl_r <= 1'b0;
			pwm_a   <= 1'b0;
			pwm_b   <= 1'b0;
		end else begin
			a_lvl_r <= a_lvl_nxt;
			b_lvl_r <= b_lvl_nxt;
			pwm_a   <= a_lvl_nxt ^ ctrl_r[hrdop_pkg::CTRL_POL_A];
			pwm_b   <= b_lvl_nxt ^ ctrl_r[hrdop_pkg::CTRL_POL_B];
		end
	end

	// sub-step of the edge taken this cycle, for the phase-clock selector
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			hires_a <= 4'h0;
			hires_b <= 4'h0;
		end else begin
			if (!hr_on) begin
				hires_a <= 4'h0;
				hires_b <= 4'h0;
			end else begin
				if (a_fall_hit) begin
					hires_a <= a_fall_e[3:0] & hr_mask;
				end else if (a_rise_hit) begin
					hires_a <= 4'h0;
				end
				if (b_fall_hit) begin
					hires_b <= b_fall_e[3:0] & hr_mask;
				end else if (b_rise_hit) begin
					hires_b <= b_rise_e[3:0] & hr_mask;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// sample triggers with oversampling, adaptive triggers, blanking

	logic          st_hit;
	logic [2:0]    os_left_r;
	logic [CW-1:0] os_tmr_r;
	logic [CW-1:0] os_space;

	// sample counts are in quarter-rate units, hence the two zero bits
	assign st_hit   = run && ({strig_r[CW-3:0], 2'b00} == cnt_r);
	assign os_space = period_r >> os_sel;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			os_left_r <= 3'h0;
			os_tmr_r  <= 14'h0000;
			conv_trig <= 1'b0;
		end else if (!run) begin
			os_left_r <= 3'h0;
			os_tmr_r  <= 14'h0000;
			conv_trig <= 1'b0;
		end else if (st_hit) begin
			conv_trig <= 1'b1;
			os_left_r <= 3'(({1'b0, 3'h1} << os_sel) - 4'h1);
			os_tmr_r  <= os_space;
		end else if (os_left_r != 3'h0 && os_tmr_r <= 14'h0001) begin
			conv_trig <= 1'b1;
			os_left_r <= os_left_r - 3'h1;
			os_tmr_r  <= os_space;
		end else begin
			conv_trig <= 1'b0;
			if (os_left_r != 3'h0) begin
				os_tmr_r <= os_tmr_r - 14'h0001;
			end
		end
	end

	// register driven trigger 2, adaptive triggers and blanking windows
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			conv_trig2   <= 1'b0;
			adapt_trig_a <= 1'b0;
			adapt_trig_b <= 1'b0;
			blank_a      <= 1'b0;
			blank_b      <= 1'b0;
		end else begin
			conv_trig2   <= run && ({strig2_r[CW-3:0], 2'b00} == cnt_r);
			adapt_trig_a <= run && !multi && (ast_a_e[EW-1:4] == cnt_r);
			adapt_trig_b <= run && !multi && (ast_b_e[EW-1:4] == cnt_r);
			if (!run || blank_a_r[hrdop_pkg::BLANK_END +: CW] == cnt_r) begin
				blank_a <= 1'b0;
			end else if (blank_a_r[CW-1:0] == cnt_r) begin
				blank_a <= 1'b1;
			end
			if (!run || blank_b_r[hrdop_pkg::BLANK_END +: CW] == cnt_r) begin
				blank_b <= 1'b0;
			end else if (blank_b_r[CW-1:0] == cnt_r) begin
				blank_b <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// sync output, phase offset, divided period interrupt

	logic [CW-1:0] phase_val;
	logic [7:0]    div_cnt_r;

	// multi mode always takes the register; normal mode may follow the duty instead
	assign phase_val = (ctrl_r[hrdop_pkg::CTRL_PH_SRC] && !multi) ? on_r[EW-1:4]
		: phase_r;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			sync_out     <= 1'b0;
			phase_offset <= 14'h0000;
		end else begin
			sync_out     <= run && (cnt_r == phase_val);
			phase_offset <= phase_val;
		end
	end

	// any 8-bit count works; the listed settings are the supported ones
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			div_cnt_r    <= 8'h00;
			period_int   <= 1'b0;
			gp_conv_trig <= 1'b0;
		end else if (!run) begin
			div_cnt_r    <= 8'h00;
			period_int   <= 1'b0;
			gp_conv_trig <= 1'b0;
		end else begin
			period_int   <= wrap && (div_cnt_r >= div_set);
			gp_conv_trig <= wrap && (div_cnt_r >= div_set);
			if (wrap) begin
				div_cnt_r <= (div_cnt_r >= div_set) ? 8'h00 : div_cnt_r + 8'h01;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// assertions

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	cnt_wrap_a: assert property (run && cnt_r >= period_r && $stable(ctrl_r)
		|=> cnt_r == 14'h0000) else $error("period counter did not restart at period");
	sync_reset_a: assert property (sync_hit ##1 run |-> cnt_r == 14'h0000)
		else $error("sync input did not reset counter");
	shadow_hold_a: assert property (run && !wrap && $stable(ctrl_r) |=> $stable(period_r))
		else $error("active period changed mid period");
	sync_out_a: assert property (run && cnt_r == phase_val |=> sync_out)
		else $error("sync output missed its threshold");
	polarity_a: assert property (pwm_a ==
		(a_lvl_r ^ $past(ctrl_r[hrdop_pkg::CTRL_POL_A]))) else $error("output a polarity wrong");
	sample_trig_a: assert property (st_hit |=> conv_trig)
		else $error("sample trigger did not fire");
	int_div_a: assert property (period_int |-> $past(wrap)
		&& $past(div_cnt_r) >= $past(div_set)) else $error("period interrupt at wrong count");
	b_fall_a: assert property (b_fall_hit |=> !b_lvl_r
		&& pwm_b == $past(ctrl_r[hrdop_pkg::CTRL_POL_B]))
		else $error("output b did not fall at its target");
	adj_b_normal_a: assert property (run && !multi && cnt_r == ev4_r[EW-1:4] |=> !b_lvl_r)
		else $error("cycle adjust b moved b in normal mode");
	hires_off_a: assert property (!hr_on |=> hires_a == 4'h0 && hires_b == 4'h0)
		else $error("hires sub-step while disabled");
	a_fall_a: assert property (a_fall_hit |=> !a_lvl_r)
		else $error("output a did not fall at its target");

	wrap_c: cover property (run && wrap);
	sync_c: cover property (sync_hit);
	os8_c: cover property (os_sel == 2'h3 && conv_trig ##[1:300] conv_trig);
	int_c: cover property (period_int && div_set != 8'h00);
endmodule
`default_nettype wire

// ### inc/hrdop_pkg.sv
// constants for the high resolution dual output pwm channel
package hrdop_pkg;
	// widths
	localparam int CNT_W     = 14;
	localparam int HR_W      = 4;
	localparam int EDGE_W    = CNT_W + HR_W;
	localparam int DUTY_W    = 24;
	localparam int DUTY_FRAC = 23;
	localparam int ADJ_W     = 16;
	localparam int DIV_W     = 8;
	localparam int HR_PHASES = 16;
	localparam int HR_SEL_MAX = 4;

	// register byte offsets
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_PERIOD = 8'h04;
	localparam logic [7:0] OFS_EV1    = 8'h08;
	localparam logic [7:0] OFS_EV2    = 8'h0c;
	localparam logic [7:0] OFS_EV3    = 8'h10;
	localparam logic [7:0] OFS_EV4    = 8'h14;
	localparam logic [7:0] OFS_ADJ_A  = 8'h18;
	localparam logic [7:0] OFS_ADJ_B  = 8'h1c;
	localparam logic [7:0] OFS_STRIG  = 8'h20;
	localparam logic [7:0] OFS_PHASE  = 8'h24;
	localparam logic [7:0] OFS_ADAPT  = 8'h28;
	localparam logic [7:0] OFS_STRIG2 = 8'h2c;
	localparam logic [7:0] OFS_BLANK_A = 8'h30;
	localparam logic [7:0] OFS_BLANK_B = 8'h34;
	localparam logic [7:0] OFS_STATUS = 8'h38;

	// control register fields
	localparam int CTRL_RUN     = 0;
	localparam int CTRL_MULTI   = 1;
	localparam int CTRL_POL_A   = 2;
	localparam int CTRL_POL_B   = 3;
	localparam int CTRL_HR_EN   = 4;
	localparam int CTRL_HR_SEL  = 5;
	localparam int CTRL_PH_CLK  = 8;
	localparam int CTRL_OS      = 9;
	localparam int CTRL_PH_SRC  = 11;
	localparam int CTRL_SYNC_EN = 12;
	localparam int CTRL_DIV     = 16;
	localparam int BLANK_END    = 16;
	localparam int STAT_PWM_A   = 16;
	localparam int STAT_PWM_B   = 17;

	// reset values
	localparam logic [31:0]       CTRL_RST   = 32'h0000_0000;
	localparam logic [CNT_W-1:0]  PERIOD_RST = 14'h00c7;
endpackage

// ### bench/hrdop_gate_drv.sv
// power stage gate driver model: measures on-time of both legs and switching period of leg a
`timescale 1ns/100ps
`default_nettype none
module hrdop_gate_drv (
	// clock and measurement control
	input  wire logic core_clk,
	input  wire logic clr,
	// gate drive legs
	input  wire logic pwm_a,
	input  wire logic pwm_b,
	// measurements
	output var  int   on_a,
	output var  int   on_b,
	output var  int   gap_a
);
	int   run_a;
	logic prev_a;

	//////////////////////////////////////////////////////////////////////////////
	// on-time per leg; spacing of leg a turn-ons gives the switching period
	always @(posedge core_clk) begin
		prev_a <= pwm_a;
		run_a <= (pwm_a === 1'b1 && prev_a === 1'b0) ? 1 : run_a + 1;
		if (pwm_a === 1'b1 && prev_a === 1'b0)
			gap_a <= run_a;
		if (clr) begin
			on_a <= 0;
			on_b <= 0;
		end else begin
			on_a <= on_a + int'(pwm_a === 1'b1);
			on_b <= on_b + int'(pwm_b === 1'b1);
		end
	end
endmodule
`default_nettype wire

// ### bench/test_high_res_dual_output_pwm.sv
// self-checking bench for the dual output pwm channel
`timescale 1ns/100ps
`default_nettype none
module test_high_res_dual_output_pwm;
	logic        core_clk, rst_b, hsel, hwrite, hready, hreadyout, hresp, clr, sync_in;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [23:0] filter_duty;
	logic [13:0] phase_offset;
	logic [3:0]  hires_a, hires_b;
	logic        pwm_a, pwm_b, sync_out, conv_trig, conv_trig2, adapt_trig_a, adapt_trig_b;
	logic        blank_a, blank_b, period_int, gp_conv_trig;
	int          on_a, on_b, gap_a, miscompares, comparisons;
	int          cnt [9];

	// the single slave's ready is the bus ready
	assign hready = hreadyout;

	hrdop_channel uut (.core_clk(core_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .filter_duty(filter_duty),
		.sync_in(sync_in), .sync_out(sync_out), .phase_offset(phase_offset), .pwm_a(pwm_a),
		.pwm_b(pwm_b), .hires_a(hires_a), .hires_b(hires_b), .conv_trig(conv_trig),
		.conv_trig2(conv_trig2), .adapt_trig_a(adapt_trig_a), .adapt_trig_b(adapt_trig_b),
		.blank_a(blank_a), .blank_b(blank_b), .period_int(period_int),
		.gp_conv_trig(gp_conv_trig));

	hrdop_gate_drv drv (.core_clk(core_clk), .clr(clr), .pwm_a(pwm_a), .pwm_b(pwm_b),
		.on_a(on_a), .on_b(on_b), .gap_a(gap_a));

	//////////////////////////////////////////////////////////////////////////////
	// pulse and window counters, cleared together with the driver model
	always @(posedge core_clk) begin
		logic [8:0] s;
		s = {blank_b, sync_out, gp_conv_trig, period_int, blank_a, adapt_trig_b, adapt_trig_a,
			conv_trig2, conv_trig};
		for (int i = 0; i < 9; i++)
			cnt[i] <= clr ? 0 : cnt[i] + int'(s[i] === 1'b1);
	end

	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end

	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	// one single word transfer; the address phase is held until ready is seen
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge core_clk);
		hsel <= 1'b1;
		haddr <= {24'h00_0000, a};
		htrans <= 2'h2;
		hwrite <= w;
		hsize <= 3'h2;
		do @(posedge core_clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge core_clk); while (hready !== 1'b1);
		q = hrdata;
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		xfer(1'b1, a, d, q);
	endtask

	task rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		xfer(1'b0, a, 32'h0000_0000, q);
		chk(q, e);
	endtask

	// settle a few periods, then count over exactly n cycles
	task meas(input int n);
		repeat (64) @(posedge core_clk);
		clr <= 1'b1;
		@(posedge core_clk);
		clr <= 1'b0;
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	// wait until a leg (b when sel is high) shows level v just after an edge
	task wait_lvl(input logic sel, input logic v);
		while ((sel ? pwm_b : pwm_a) !== v) begin
			@(posedge core_clk);
			#1;
		end
	endtask

	task test_regs;
		rd(hrdop_pkg::OFS_PERIOD, 32'h0000_00c7);
		rd(hrdop_pkg::OFS_CTRL, 32'h0000_0000);
		wr(hrdop_pkg::OFS_EV2, 32'h0000_0065);
		rd(hrdop_pkg::OFS_EV2, 32'h0000_0065);
		rd(8'h3c, 32'h0000_0000);
		chk({31'h0000_0000, hresp}, 32'h0000_0000);
		$display("test regs done");
	endtask

	// period 10 counts: a 2..6 (+1 adjust), b 3..8 (+1 adjust)
	task test_multi;
		wr(hrdop_pkg::OFS_PERIOD, 32'h0000_0009);
		wr(hrdop_pkg::OFS_EV1, 32'h0000_0002);
		wr(hrdop_pkg::OFS_EV3, 32'h0000_0030);
		wr(hrdop_pkg::OFS_EV4, 32'h0000_0080);
		wr(hrdop_pkg::OFS_ADJ_A, 32'h0000_0010);
		wr(hrdop_pkg::OFS_ADJ_B, 32'h0000_0010);
		wr(hrdop_pkg::OFS_PHASE, 32'h0000_0005);
		wr(hrdop_pkg::OFS_CTRL, 32'h0000_0003);
		meas(20);
		chk(on_a, 10);
		chk(on_b, 12);
		chk(gap_a, 10);
		chk(cnt[7], 2);
		chk(phase_offset, 14'h0005);
		chk(hires_a, 4'h0);
		wr(hrdop_pkg::OFS_ADJ_A, 32'h0000_0000);
		wr(hrdop_pkg::OFS_CTRL, 32'h0000_000f);
		meas(20);
		chk(on_a, 12);
		chk(on_b, 8);
		// hires on, step select 1 masks sub-step bit 0; wholes of b stay 3 and 8
		wr(hrdop_pkg::OFS_EV3, 32'h0000_0037);
		wr(hrdop_pkg::OFS_EV4, 32'h0000_007b);
		wr(hrdop_pkg::OFS_CTRL, 32'h0000_0133);
		wr(hrdop_pkg::OFS_PERIOD, 32'h0000_000e);
		meas(30);
		chk(gap_a, 15);
		chk(on_a, 8);
		chk(on_b, 10);
		wait_lvl(1'b0, 1'b1);
		wait_lvl(1'b0, 1'b0);
		chk(hires_a, 4'h4);
		wait_lvl(1'b1, 1'b0);
		wait_lvl(1'b1, 1'b1);
		chk(hires_b, 4'h6);
		wait_lvl(1'b1, 1'b0);
		chk(hires_b, 4'ha);
		$display("test multi done");
	endtask

	// counter held at zero by a standing sync request
	task test_sync;
		wr(hrdop_pkg::OFS_PERIOD, 32'h0000_0009);
		wr(hrdop_pkg::OFS_CTRL, 32'h0000_1003);
		sync_in <= 1'b1;
		meas(20);
		chk(on_a, 0);
		chk(cnt[7], 0);
		rd(hrdop_pkg::OFS_STATUS, 32'h0000_0000);
		sync_in <= 1'b0;
		$display("test sync done");
	endtask

	// period 20 counts, half duty is 9.5 counts on the 1/16 scale
	task test_normal;
		wr(hrdop_pkg::OFS_PERIOD, 32'h0000_0013);
		wr(hrdop_pkg::OFS_EV2, 32'h0000_0000);
		wr(hrdop_pkg::OFS_EV3, 32'h0000_0020);
		wr(hrdop_pkg::OFS_EV4, 32'h0000_0120);
		wr(hrdop_pkg::OFS_ADJ_A, 32'h0000_0010);
		wr(hrdop_pkg::OFS_ADJ_B, 32'h0000_0100);
		wr(hrdop_pkg::OFS_ADAPT, 32'h0000_0000);
		filter_duty <= 24'h40_0000;
		wr(hrdop_pkg::OFS_CTRL, 32'h0000_0801);
		meas(40);
		chk(on_a, 20);
		chk(on_b, 8);
		chk(cnt[2], 2);
		chk(cnt[3], 2);
		chk(phase_offset, 14'h0009);
		filter_duty <= 24'h80_0000;
		meas(40);
		chk(on_a, 2);
		chk(on_b, 26);
		$display("test normal done");
	endtask

	// sample trigger at count 4 of a 64 count period, all oversampling codes
	task test_trig;
		wr(hrdop_pkg::OFS_PERIOD, 32'h0000_003f);
		wr(hrdop_pkg::OFS_STRIG, 32'h0000_0001);
		wr(hrdop_pkg::OFS_STRIG2, 32'h0000_0002);
		wr(hrdop_pkg::OFS_BLANK_A, 32'h0014_000a);
		wr(hrdop_pkg::OFS_BLANK_B, 32'h0030_0028);
		for (int os = 0; os < 4; os++) begin
			wr(hrdop_pkg::OFS_CTRL, 32'h0000_0003 | (os << 9));
			meas(128);
			chk(cnt[0], 2 << os);
			chk(cnt[1], 2);
			chk(cnt[4], 20);
			chk(cnt[8], 16);
		end
		$display("test trig done");
	endtask

	// divided period interrupt over 16 periods of 10 counts
	task test_int;
		int div [5] = '{0, 1, 3, 7, 15};
		wr(hrdop_pkg::OFS_PERIOD, 32'h0000_0009);
		foreach (div[i]) begin
			wr(hrdop_pkg::OFS_CTRL, 32'h0000_0003 | (div[i] << 16));
			meas(160);
			chk(cnt[5], 16 / (div[i] + 1));
			chk(cnt[6], 16 / (div[i] + 1));
		end
		$display("test int done");
	endtask

	task stop_test;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	//////////////////////////////////////////////////////////////////////////////
	// reset, then the scenarios in turn
	initial begin
		miscompares = 0;
		comparisons = 0;
		rst_b = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0000_0000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0000_0000;
		filter_duty = 24'h00_0000;
		sync_in = 1'b0;
		clr = 1'b1;
		repeat (6) @(posedge core_clk);
		rst_b <= 1'b1;
		test_regs;
		test_multi;
		test_sync;
		test_normal;
		test_trig;
		test_int;
		stop_test;
	end

	// watchdog well beyond the few thousand cycles the scenarios need
	initial begin
		repeat (40000) @(posedge core_clk);
		miscompares++;
		stop_test;
	end
endmodule
`default_nettype wire
